//--- inc/tbl_pkg.sv
package tbl_pkg;
  // Clocking and reset-to-boot delay
  localparam int SYS_CLK_MHZ  = 20;
  localparam int BOOT_DLY_NS  = 15000;
  localparam int BOOT_DLY_CYC = (BOOT_DLY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DLY_W        = 9;
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(BOOT_DLY_CYC - 1);

  // Register bus map, byte addresses
  localparam int AVS_AW = 4;
  localparam logic [AVS_AW-1:0] REG_PLL  = 4'h0;
  localparam logic [AVS_AW-1:0] REG_STAT = 4'h4;
  localparam logic [AVS_AW-1:0] REG_SEC  = 4'h8;
  localparam logic [AVS_AW-1:0] REG_CRC  = 4'hc;

  // PLL configuration word layout
  localparam int R_LSB  = 0;
  localparam int R_W    = 6;
  localparam int F_LSB  = 8;
  localparam int F_W    = 12;
  localparam int OD_LSB = 24;
  localparam int OD_W   = 3;
  localparam logic [31:0] PLL_MASK = 32'h070fff3f;
  localparam logic [OD_W-1:0] OD_BOOT = 3'h1;
  localparam logic [R_W-1:0]  R_BOOT  = 6'h00;
  localparam logic [F_W-1:0]  F_X40   = 12'h09f;
  localparam logic [F_W-1:0]  F_X16   = 12'h03f;
  localparam logic [F_W-1:0]  F_X8    = 12'h01f;
  localparam logic [F_W-1:0]  F_X4    = 12'h00f;

  // Boot sources and image checking
  localparam int SEC_BOOT_BIT = 5;
  localparam int OTP_AW = 11;
  localparam logic [OTP_AW-1:0] OTP_SEC_ROW = 11'h7ff;
  localparam logic [OTP_AW-1:0] OTP_IMG_ROW = 11'h000;
  localparam logic [31:0] FL_HDR   = 32'h03000000;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_SKIP = 32'h0d15ab1e;

  typedef enum logic [2:0] {
    ST_RST  = 3'h0, ST_DLY = 3'h1, ST_SEC = 3'h3, ST_LEN  = 3'h2,
    ST_PROG = 3'h6, ST_CHK = 3'h7, ST_RUN = 3'h5, ST_FAIL = 3'h4
  } tbl_state_t;

  // Boot PLL word from the two ratio straps
  function automatic logic [31:0] pll_boot(input logic hi, input logic lo);
    logic [F_W-1:0] f;
    case ({hi, lo})
      2'b00:   f = F_X40;
      2'b11:   f = F_X16;
      2'b10:   f = F_X8;
      default: f = F_X4;
    endcase
    return (32'(OD_BOOT) << OD_LSB) | (32'(f) << F_LSB) | (32'(R_BOOT) << R_LSB);
  endfunction

  // Reflected CRC-32, one byte, LSB first
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction
endpackage

//--- tb/tbl_flash_model.sv
module tbl_flash_model (
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic slow,
  output logic      miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:255];
  logic [31:0] hdr;
  int          nbit;
  // Frame start clears the command shifter
  always @(negedge cs_n) begin
    nbit = 0;
    hdr = '0;
  end
  // Mode 0: command bits taken on rising SCLK, MSB first
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (nbit < 32) hdr = {hdr[30:0], mosi};
      nbit = nbit + 1;
    end
  end
  // Data bits change on falling SCLK; slow mode lags nearly a system cycle, off the sampling edge
  always @(negedge sclk) begin
    if (!cs_n && nbit >= 32) begin
      if (slow) #45;
      miso = mem[(nbit - 32) / 8][7 - (nbit - 32) % 8];
    end
  end
  // Undriven line toggles, so a stale bit never passes for data
  initial miso = 1'b0;
  always #50 if (cs_n || nbit < 32) miso = ~miso;
endmodule

//--- tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tbl_pkg::*;
  logic        clk, sys_rst, chip_rst_n, slow, cs_fell;
  logic        clock_ratio_strap_hi, clock_ratio_strap_lo, tile2_link_boot_strap;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, otp_rdata;
  logic        gpio_pd_en, tile2_link_boot, flash_cs_n, flash_sclk, flash_mosi, flash_miso;
  logic [2:0]  pll_output_divider;
  logic [11:0] pll_feedback;
  logic [5:0]  pll_ref_divider;
  logic [10:0] otp_addr;
  logic        ram_we, core_run, boot_fail;
  logic [16:0] ram_addr, core_pc;
  logic [7:0]  ram_wdata;
  logic [7:0]  img [0:255];
  logic [31:0] otp [0:2047];
  int          seed, n_img, ram_idx, n_mismatch, cmp_count;
  localparam logic [1:0] STRAP_TAB [5] = '{2'b00, 2'b11, 2'b10, 2'b01, 2'b00};
  localparam int         LEN_TAB [5]   = '{3, 0, 2, 2, 4};
  localparam int         MODE_TAB [5]  = '{0, 0, 1, 2, 0};

  tbl_top #(.RAM_AW(17), .SPI_HALF(4)) i_dut (
    .SYS_CLK(clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .CHIP_RST_N(chip_rst_n),
    .CLOCK_RATIO_STRAP_HI(clock_ratio_strap_hi), .CLOCK_RATIO_STRAP_LO(clock_ratio_strap_lo),
    .TILE2_LINK_BOOT_STRAP(tile2_link_boot_strap), .FLASH_MISO(flash_miso), .OTP_RDATA(otp_rdata),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .GPIO_PD_EN(gpio_pd_en), .TILE2_LINK_BOOT(tile2_link_boot), .PLL_OUTPUT_DIVIDER(pll_output_divider),
    .PLL_FEEDBACK(pll_feedback), .PLL_REF_DIVIDER(pll_ref_divider), .FLASH_CS_N(flash_cs_n),
    .FLASH_SCLK(flash_sclk), .FLASH_MOSI(flash_mosi), .OTP_ADDR(otp_addr), .RAM_WE(ram_we),
    .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata), .CORE_RUN(core_run), .CORE_PC(core_pc), .BOOT_FAIL(boot_fail)
  );
  tbl_flash_model i_flash (.cs_n(flash_cs_n), .sclk(flash_sclk), .mosi(flash_mosi), .slow(slow), .miso(flash_miso));

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // OTP rows answer one cycle after the address
  always @(posedge clk) otp_rdata <= otp[otp_addr];

  // Every program byte must land at the next RAM address
  always @(posedge clk) begin
    if (ram_we === 1'b1) begin
      check(ram_addr, ram_idx);
      check(ram_wdata, img[4 + ram_idx]);
      ram_idx++;
    end
    if (flash_cs_n === 1'b0) cs_fell = 1'b1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_mismatch++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic logic [11:0] fb_exp(input logic [1:0] s);
    case (s)
      2'b00: return 12'h09f;
      2'b11: return 12'h03f;
      2'b10: return 12'h01f;
      default: return 12'h00f;
    endcase
  endfunction

  // Reference CRC over the first n image bytes, LSB first, inverted
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, img[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    return ~c;
  endfunction

  // Image: length, program, check word; mode 1 skip value, mode 2 corrupt
  task automatic build(input int len, input int mode);
    logic [31:0] c;
    n_img = 8 + 4 * len;
    for (int i = 0; i < 4; i++) img[i] = 8'(len >> (8 * i));
    for (int i = 0; i < 4 * len; i++) img[4 + i] = 8'($random(seed));
    c = (mode == 1) ? CRC_SKIP : crc_of(4 + 4 * len) ^ ((mode == 2) ? 32'h1 : 32'h0);
    for (int i = 0; i < 4; i++) img[4 + 4 * len + i] = c[8 * i +: 8];
    for (int i = 0; i < n_img; i++) begin
      i_flash.mem[i] = img[i];
      otp[i / 4][8 * (i % 4) +: 8] = img[i];
    end
  endtask

  // Pin reset pulse, strap capture, then a whole boot
  task automatic run_boot(input int k);
    logic [1:0]  s;
    logic [31:0] sec, q;
    int          n, len, mode;
    s = STRAP_TAB[k];
    len = LEN_TAB[k];
    mode = MODE_TAB[k];
    sec = ($random(seed) & 32'hffffffdf) | ((k == 4) ? 32'h20 : 32'h0);
    otp[11'h7ff] = sec;
    build(len, mode);
    chip_rst_n <= 1'b0;
    {clock_ratio_strap_hi, clock_ratio_strap_lo} <= s;
    tile2_link_boot_strap <= k[0];
    slow <= (k == 2);
    repeat (6) @(posedge clk);
    check(gpio_pd_en, 1'b1);
    ram_idx = 0;
    cs_fell = 1'b0;
    chip_rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(gpio_pd_en, 1'b0);
    check({pll_output_divider, pll_ref_divider}, 9'h040);
    check(pll_feedback, fb_exp(s));
    check(tile2_link_boot, k[0]);
    n = 8;
    while (flash_cs_n !== 1'b0 && core_run !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (k != 4) check(n >= 300 && n <= 3000, 1'b1);
    while (core_run !== 1'b1 && boot_fail !== 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    check(core_run, mode != 2);
    check(boot_fail, mode == 2);
    check(core_pc, 32'h0);
    check(ram_idx, 4 * len);
    check(cs_fell, k != 4);
    if (k != 4) check(i_flash.hdr, 32'h03000000);
    bus(1'b0, REG_SEC, 32'h0, q);
    check(q, sec);
    bus(1'b0, REG_STAT, 32'h0, q);
    check(q[6:3], {k[0], k == 4, mode == 2, mode != 2});
  endtask

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence: five boots over all straps and sources, then PLL rewrite
  initial begin
    logic [31:0] d, q, e, m;
    logic [3:0]  be;
    seed = 76;
    n_mismatch = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    chip_rst_n = 1'b0;
    slow = 1'b0;
    cs_fell = 1'b0;
    {clock_ratio_strap_hi, clock_ratio_strap_lo, tile2_link_boot_strap} = 3'h0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    otp_rdata = 32'h0;
    for (int i = 0; i < 2048; i++) otp[i] = 32'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(gpio_pd_en, 1'b1);
    for (int k = 0; k < 5; k++) run_boot(k);
    // Last boot left the strap word; odd passes write random lanes only
    e = {5'h0, 3'h1, 4'h0, fb_exp(STRAP_TAB[4]), 8'h00};
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      be = k[0] ? 4'($random(seed)) : 4'hf;
      for (int b = 0; b < 4; b++) m[8 * b +: 8] = {8{be[b]}};
      e = ((e & ~m) | (d & m)) & PLL_MASK;
      avs_byteenable <= be;
      bus(1'b1, REG_PLL, d, q);
      bus(1'b0, REG_PLL, 32'h0, q);
      check(q, e);
      check({pll_output_divider, pll_feedback, pll_ref_divider}, {e[26:24], e[19:8], e[5:0]});
    end
    bus(1'b1, REG_STAT, 32'hffffffff, q);
    bus(1'b0, REG_STAT, 32'h0, q);
    check(q[4:3], 2'b01);
    bus(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0);
    print_verdict();
  end

  // Watchdog well past the longest expected run
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule

//--- verilog/tbl_top.sv
// Operation
// RULE_01 - Chip reset pin low holds boot in reset with GPIO pull-downs on.
// RULE_02 - After pin release, wait the internal reset time, then start booting.
// RULE_03 - Ratio straps pick PLL ratio 40, 16, 8 or 4; upper strap first.
// RULE_04 - Boot PLL uses divider 1, reference 0, feedback 159/63/31/15.
// RULE_05 - Software keeps PLL fields within their legal ranges.
// RULE_06 - Software may rewrite the PLL configuration after boot.
// RULE_07 - Ratio straps stay constant during and after reset release.
// RULE_08 - Tile 2 link strap high at release makes tile 2 boot from link.
// RULE_09 - Secure-boot bit set boots from OTP, else from internal flash.
// RULE_10 - Flash image is read through the tile 0 flash port.
// RULE_11 - Image is length word, four times that many bytes, then check word.
// RULE_12 - Length and check words arrive least significant byte first.
// RULE_13 - Check word 0x0D15AB1E skips CRC checking.
// RULE_14 - Program goes to lowest RAM address; execution starts there.
// RULE_15 - CRC covers length bytes and program bytes, not the check word.
// RULE_16 - CRC uses reflected polynomial 0xEDB88320, LSB first.
// RULE_17 - CRC starts all ones; inverted remainder is compared.
// RULE_18 - Secure boot starts at OTP address zero, skipping boot ROM.
// RULE_19 - Security word loads from OTP at power up; OTP image runs.
// RULE_20 - CRC mismatch keeps the program stopped.
module tbl_top #(
  parameter int RAM_AW   = 17,
  parameter int SPI_HALF = 4
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          SYS_RST,
  input  wire logic                          CLK_EN,
  input  wire logic                          CHIP_RST_N,
  input  wire logic                          CLOCK_RATIO_STRAP_HI,
  input  wire logic                          CLOCK_RATIO_STRAP_LO,
  input  wire logic                          TILE2_LINK_BOOT_STRAP,
  input  wire logic                          FLASH_MISO,
  input  wire logic [31:0]                   OTP_RDATA,
  input  wire logic [tbl_pkg::AVS_AW-1:0]    AVS_ADDRESS,
  input  wire logic                          AVS_READ,
  input  wire logic                          AVS_WRITE,
  input  wire logic [31:0]                   AVS_WRITEDATA,
  input  wire logic [3:0]                    AVS_BYTEENABLE,
  output logic [31:0]                        AVS_READDATA,
  output logic                               AVS_WAITREQUEST,
  output logic                               GPIO_PD_EN,
  output logic                               TILE2_LINK_BOOT,
  output logic [tbl_pkg::OD_W-1:0]           PLL_OUTPUT_DIVIDER,
  output logic [tbl_pkg::F_W-1:0]            PLL_FEEDBACK,
  output logic [tbl_pkg::R_W-1:0]            PLL_REF_DIVIDER,
  output logic                               FLASH_CS_N,
  output logic                               FLASH_SCLK,
  output logic                               FLASH_MOSI,
  output logic [tbl_pkg::OTP_AW-1:0]         OTP_ADDR,
  output logic                               RAM_WE,
  output logic [RAM_AW-1:0]                  RAM_ADDR,
  output logic [7:0]                         RAM_WDATA,
  output logic                               CORE_RUN,
  output logic [RAM_AW-1:0]                  CORE_PC,
  output logic                               BOOT_FAIL
);
  import tbl_pkg::*;

  // Pin synchronisers: reset pin, straps, flash data
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic       rstn_s;
  logic       hi_s;
  logic       lo_s;
  logic       t2_s;
  logic       miso_s;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end else if (CLK_EN) begin
      s1_q <= {CHIP_RST_N, CLOCK_RATIO_STRAP_HI, CLOCK_RATIO_STRAP_LO, TILE2_LINK_BOOT_STRAP, FLASH_MISO};
      s2_q <= s1_q;
    end
  end
  assign {rstn_s, hi_s, lo_s, t2_s, miso_s} = s2_q;

  // Bus slave: one wait cycle, then the transfer completes
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic        req;
  logic        pll_wr;
  logic [31:0] be_mask;
  tbl_state_t  st_q;
  tbl_state_t  st_d;
  logic [31:0] sec_q;
  logic [31:0] crc_q;
  logic [31:0] pll_q;
  logic        otp_src_q;
  logic        run_q;
  logic        fail_q;
  logic        t2_q;

  assign req    = (AVS_READ | AVS_WRITE) & CLK_EN;
  assign pll_wr = req & ~wait_q & AVS_WRITE & (AVS_ADDRESS == REG_PLL);
  always_comb begin
    for (int b = 0; b < 4; b++) be_mask[b*8 +: 8] = {8{AVS_BYTEENABLE[b]}};
  end

  always_comb begin
    wait_d = 1'b1;
    rd_d   = rd_q;
    if (req && wait_q) begin
      wait_d = 1'b0;
      case (AVS_ADDRESS)
        REG_PLL:  rd_d = pll_q;
        REG_STAT: rd_d = 32'({t2_q, otp_src_q, fail_q, run_q, st_q});
        REG_SEC:  rd_d = sec_q;
        REG_CRC:  rd_d = crc_q;
        default:  rd_d = 32'h00000000; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wait_q <= 1'b1;
      rd_q   <= 32'h00000000;
    end else if (CLK_EN) begin
      wait_q <= wait_d;
      rd_q   <= rd_d;
    end
  end
  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA    = rd_q;

  // Boot engine state
  logic [DLY_W-1:0]  dly_q,  dly_d;
  logic [31:0]       sec_d,  crc_d,  pll_d,  w_q,  w_d,  tx_q,  tx_d;
  logic              otp_src_d, run_d, fail_d, t2_d, pd_q, pd_d;
  logic [OTP_AW-1:0] oa_q,   oa_d;
  logic [1:0]        obi_q,  obi_d,  bc_q,  bc_d;
  logic              ordy_q, ordy_d, cs_n_q, cs_n_d, sclk_q, sclk_d;
  logic              mosi_q, mosi_d, hdr_q, hdr_d, bv_q, bv_d;
  logic [7:0]        div_q,  div_d,  rx_q,  rx_d,  bd_q,  bd_d;
  logic [5:0]        nb_q,   nb_d;
  logic [33:0]       rem_q,  rem_d;
  logic              we_q,   we_d;
  logic [RAM_AW-1:0] ptr_q,  ptr_d,  ra_q,  ra_d;
  logic [7:0]        wd_q,   wd_d;
  logic              fetch;
  logic              tick;

  assign fetch = (st_q == ST_LEN || st_q == ST_PROG || st_q == ST_CHK) && !bv_q;
  assign tick  = div_q == 8'(SPI_HALF - 1);

  // Next-state logic for sequencing, byte fetch and image parsing
  always_comb begin
    st_d = st_q;  dly_d = dly_q;  sec_d = sec_q;  crc_d = crc_q;  pll_d = pll_q;
    w_d = w_q;  tx_d = tx_q;  otp_src_d = otp_src_q;  run_d = run_q;  fail_d = fail_q;
    t2_d = t2_q;  pd_d = pd_q;  oa_d = oa_q;  obi_d = obi_q;  bc_d = bc_q;
    ordy_d = ordy_q;  cs_n_d = cs_n_q;  sclk_d = sclk_q;  mosi_d = mosi_q;
    hdr_d = hdr_q;  div_d = div_q;  rx_d = rx_q;  bd_d = bd_q;  nb_d = nb_q;
    rem_d = rem_q;  ptr_d = ptr_q;  ra_d = ra_q;  wd_d = wd_q;
    bv_d = 1'b0;
    we_d = 1'b0;

    // OTP byte source, one cycle read latency per row
    if (otp_src_q && fetch) begin // RULE_18
      if (!ordy_q) begin
        ordy_d = 1'b1;
      end else begin
        bv_d  = 1'b1;
        bd_d  = OTP_RDATA[{obi_q, 3'h0} +: 8];
        obi_d = obi_q + 2'h1;
        if (obi_q == 2'h3) begin
          oa_d   = oa_q + OTP_AW'(1);
          ordy_d = 1'b0;
        end
      end
    end

    // Flash serial engine, mode 0, MSB first
    if (nb_q != 6'h00) begin // RULE_10
      div_d = tick ? 8'h00 : div_q + 8'h01;
      if (tick) begin
        sclk_d = ~sclk_q;
        if (!sclk_q) begin
          rx_d = {rx_q[6:0], miso_s};
        end else begin
          nb_d   = nb_q - 6'h01;
          tx_d   = tx_q << 1;
          mosi_d = tx_q[30];
          if (nb_q == 6'h01) begin
            hdr_d = 1'b0;
            bv_d  = !hdr_q;
            bd_d  = rx_q;
          end
        end
      end
    end else if (!otp_src_q && fetch && !hdr_q && !cs_n_q) begin
      nb_d  = 6'h08;
      div_d = 8'h00;
    end

    case (st_q)
      ST_RST: begin
        if (rstn_s) begin
          pd_d  = 1'b0;
          pll_d = pll_boot(hi_s, lo_s); // RULE_03 RULE_04
          t2_d  = t2_s; // RULE_08
          dly_d = '0;
          oa_d  = OTP_SEC_ROW;
          st_d  = ST_DLY;
        end
      end
      ST_DLY: begin
        dly_d = dly_q + DLY_W'(1);
        if (dly_q == DLY_LAST) begin // RULE_02
          ordy_d = 1'b0;
          st_d   = ST_SEC;
        end
      end
      ST_SEC: begin
        ordy_d = 1'b1;
        if (ordy_q) begin
          sec_d     = OTP_RDATA; // RULE_19
          otp_src_d = OTP_RDATA[SEC_BOOT_BIT]; // RULE_09
          oa_d      = OTP_IMG_ROW; // RULE_18
          obi_d     = 2'h0;
          ordy_d    = 1'b0;
          crc_d     = CRC_INIT; // RULE_17
          bc_d      = 2'h0;
          ptr_d     = '0;
          if (!OTP_RDATA[SEC_BOOT_BIT]) begin
            cs_n_d = 1'b0;
            tx_d   = FL_HDR;
            mosi_d = FL_HDR[31];
            hdr_d  = 1'b1;
            nb_d   = 6'h20;
            div_d  = 8'h00;
          end
          st_d = ST_LEN;
        end
      end
      ST_LEN, ST_PROG, ST_CHK: begin
        if (bv_q) begin
          w_d  = {bd_q, w_q[31:8]}; // RULE_12
          bc_d = bc_q + 2'h1;
          if (st_q != ST_CHK) crc_d = crc8(crc_q, bd_q); // RULE_15 RULE_16
          if (st_q == ST_LEN && bc_q == 2'h3) begin // RULE_11
            rem_d = {w_d, 2'b00};
            st_d  = (w_d == 32'h0) ? ST_CHK : ST_PROG;
          end
          if (st_q == ST_PROG) begin // RULE_14
            we_d  = 1'b1;
            ra_d  = ptr_q;
            wd_d  = bd_q;
            ptr_d = ptr_q + RAM_AW'(1);
            rem_d = rem_q - 34'h1;
            if (rem_q == 34'h1) st_d = ST_CHK;
          end
          if (st_q == ST_CHK && bc_q == 2'h3) begin
            cs_n_d = 1'b1;
            if (w_d == CRC_SKIP || w_d == ~crc_q) begin // RULE_13 RULE_17
              run_d = 1'b1;
              st_d  = ST_RUN;
            end else begin
              fail_d = 1'b1; // RULE_20
              st_d   = ST_FAIL;
            end
          end
        end
      end
      ST_RUN, ST_FAIL: begin
      end
      default: st_d = ST_RST;
    endcase

    // Software may retune the PLL at any time; bits outside the fields are dropped
    if (pll_wr) pll_d = ((pll_q & ~be_mask) | (AVS_WRITEDATA & be_mask)) & PLL_MASK; // RULE_06 RULE_05

    // Pin reset overrides state, pull-downs, run and fail flags and strobes, and parks the flash port; PLL writes still land
    if (!rstn_s) begin // RULE_01
      st_d = ST_RST;  pd_d = 1'b1;  run_d = 1'b0;  fail_d = 1'b0;
      cs_n_d = 1'b1;  sclk_d = 1'b0;  nb_d = 6'h00;  hdr_d = 1'b0;
      bv_d = 1'b0;  we_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_q <= ST_RST;  dly_q <= '0;  sec_q <= 32'h0;  crc_q <= CRC_INIT;
      pll_q <= 32'h0;  w_q <= 32'h0;  tx_q <= 32'h0;  otp_src_q <= 1'b0;
      run_q <= 1'b0;  fail_q <= 1'b0;  t2_q <= 1'b0;  pd_q <= 1'b1;
      oa_q <= '0;  obi_q <= 2'h0;  bc_q <= 2'h0;  ordy_q <= 1'b0;
      cs_n_q <= 1'b1;  sclk_q <= 1'b0;  mosi_q <= 1'b0;  hdr_q <= 1'b0;
      div_q <= 8'h00;  rx_q <= 8'h00;  bd_q <= 8'h00;  nb_q <= 6'h00;
      rem_q <= 34'h0;  ptr_q <= '0;  ra_q <= '0;  wd_q <= 8'h00;
      bv_q <= 1'b0;  we_q <= 1'b0;
    end else if (CLK_EN) begin
      st_q <= st_d;  dly_q <= dly_d;  sec_q <= sec_d;  crc_q <= crc_d;
      pll_q <= pll_d;  w_q <= w_d;  tx_q <= tx_d;  otp_src_q <= otp_src_d;
      run_q <= run_d;  fail_q <= fail_d;  t2_q <= t2_d;  pd_q <= pd_d;
      oa_q <= oa_d;  obi_q <= obi_d;  bc_q <= bc_d;  ordy_q <= ordy_d;
      cs_n_q <= cs_n_d;  sclk_q <= sclk_d;  mosi_q <= mosi_d;  hdr_q <= hdr_d;
      div_q <= div_d;  rx_q <= rx_d;  bd_q <= bd_d;  nb_q <= nb_d;
      rem_q <= rem_d;  ptr_q <= ptr_d;  ra_q <= ra_d;  wd_q <= wd_d;
      bv_q <= bv_d;  we_q <= we_d;
    end
  end

  // Outputs straight from flops; entry point is always RAM base
  assign GPIO_PD_EN         = pd_q;
  assign TILE2_LINK_BOOT    = t2_q;
  assign PLL_OUTPUT_DIVIDER = pll_q[OD_LSB +: OD_W];
  assign PLL_FEEDBACK       = pll_q[F_LSB +: F_W];
  assign PLL_REF_DIVIDER    = pll_q[R_LSB +: R_W];
  assign FLASH_CS_N         = cs_n_q;
  assign FLASH_SCLK         = sclk_q;
  assign FLASH_MOSI         = mosi_q;
  assign OTP_ADDR           = oa_q;
  assign RAM_WE             = we_q;
  assign RAM_ADDR           = ra_q;
  assign RAM_WDATA          = wd_q;
  assign CORE_RUN           = run_q;
  assign CORE_PC            = ptr_q & '0; // RULE_14
  assign BOOT_FAIL          = fail_q;

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  sequence pll_acc;
    pll_wr && AVS_BYTEENABLE == 4'hf;
  endsequence
  sequence boot_rel;
    $past(st_q) == ST_RST && st_q == ST_DLY && !$past(pll_wr);
  endsequence
  sequence img_start;
    $past(st_q) == ST_SEC && st_q == ST_LEN;
  endsequence

  pin_reset_a: assert property (!rstn_s && CLK_EN |=> GPIO_PD_EN && st_q == ST_RST) // RULE_01
    else $error("pin reset not honoured");
  boot_delay_a: assert property ($past(st_q) == ST_DLY && st_q == ST_SEC |-> $past(dly_q) == DLY_LAST) // RULE_02
    else $error("boot delay wrong");
  strap_ratio_a: assert property (boot_rel |-> pll_q == pll_boot($past(hi_s), $past(lo_s))) // RULE_03
    else $error("boot PLL word wrong");
  link_strap_a: assert property (boot_rel |-> TILE2_LINK_BOOT == $past(t2_s)) // RULE_08
    else $error("tile 2 strap not captured");
  pll_write_a: assert property (pll_acc |=> PLL_FEEDBACK == $past(AVS_WRITEDATA[F_LSB +: F_W])) // RULE_06
    else $error("PLL write lost");
  boot_src_a: assert property (img_start |-> otp_src_q == sec_q[SEC_BOOT_BIT] && FLASH_CS_N == otp_src_q) // RULE_09
    else $error("boot source wrong");
  crc_init_a: assert property (img_start |-> crc_q == CRC_INIT && ptr_q == '0) // RULE_17
    else $error("image start state wrong");
  crc_skip_a: assert property (bv_q && CLK_EN && rstn_s && st_q == ST_CHK && bc_q == 2'h3 &&
      {bd_q, w_q[31:8]} == CRC_SKIP |=> CORE_RUN) // RULE_13
    else $error("skip word not honoured");
  fail_halt_a: assert property (fail_q && rstn_s |=> fail_q && !CORE_RUN) // RULE_20
    else $error("failed image started");
endmodule
